// *** pkg/afm_pkg.sv ***
package afm_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] AFM_ADDR_REF    = 8'h00;
    localparam logic [7:0] AFM_ADDR_INPUT  = 8'h04;
    localparam logic [7:0] AFM_ADDR_BURN   = 8'h08;
    localparam logic [7:0] AFM_ADDR_EXC    = 8'h0c;
    localparam logic [7:0] AFM_ADDR_STATUS = 8'h10;
    localparam logic [7:0] AFM_ADDR_ROUTE  = 8'h14;

    // ------------------------------------------------------------
    // Field codes
    // ------------------------------------------------------------
    localparam logic [1:0] AFM_REF_INTERNAL = 2'h0;
    localparam logic [1:0] AFM_REF_SUPPLY   = 2'h1;
    localparam logic [1:0] AFM_REF_EXT0     = 2'h2;
    localparam logic [1:0] AFM_REF_EXT1     = 2'h3;
    localparam logic [2:0] AFM_GAIN_MAX     = 3'h7;
    localparam logic [2:0] AFM_BURN_MAX     = 3'h4;
    localparam int         AFM_ROUTE_W      = 4;
    localparam int         AFM_LEVEL_W      = 4;

    // Reference source that reaches the converter.
    typedef enum logic [2:0] {
        AFM_SRC_INTERNAL = 3'b000,
        AFM_SRC_SUPPLY   = 3'b001,
        AFM_SRC_EXT01    = 3'b010,
        AFM_SRC_EXT23    = 3'b011,
        AFM_SRC_MIXED    = 3'b100
    } afm_src_e;

    typedef struct packed {
        logic amp_high_alarm;
        logic amp_low_alarm;
        logic ref_low_alarm;
    } afm_status_s;

    typedef struct packed {
        logic [AFM_ROUTE_W-1:0] route;
        logic [AFM_LEVEL_W-1:0] level;
    } afm_exc_s;

endpackage

// *** core/afm_afe_monitor.sv ***
// Local design decisions: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/100ps
`default_nettype none
module afm_afe_monitor
    import afm_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        resetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        conv_start,
    input  wire logic        mux_switching,
    input  wire logic        cmp_outp_high,
    input  wire logic        cmp_outn_high,
    input  wire logic        cmp_outp_low,
    input  wire logic        cmp_outn_low,
    input  wire logic        cmp_ref_low,
    output afm_status_s      status,
    output afm_src_e         ref_source,
    output logic             internal_ref_on,
    output logic             level_shift_switch,
    output logic             amp_bypass,
    output logic      [7:0]  gain_factor,
    output logic             burn_pullup,
    output logic      [2:0]  burn_level,
    output afm_exc_s         excitation_source_1,
    output afm_exc_s         excitation_source_2
);

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    // All analog-side signals arrive asynchronously and pass two flops.
    logic [6:0] sync1_reg;
    logic [6:0] sync2_reg;
    logic       conv_d_reg;
    always_ff @(posedge clk) begin
        if (!resetn) begin
            sync1_reg <= 7'h00;
            sync2_reg <= 7'h00;
            conv_d_reg <= 1'b0;
        end else begin
            sync1_reg <= {conv_start, mux_switching, cmp_outp_high, cmp_outn_high,
                          cmp_outp_low, cmp_outn_low, cmp_ref_low};
            sync2_reg <= sync1_reg;
            conv_d_reg <= sync2_reg[6];
        end
    end

    logic conv_pulse;
    logic mux_busy;
    logic over_high;
    logic over_low;
    logic ref_low;
    assign conv_pulse = sync2_reg[6] & ~conv_d_reg;
    assign mux_busy   = sync2_reg[5];
    assign over_high  = (sync2_reg[4] | sync2_reg[3]) & ~mux_busy;
    assign over_low   = (sync2_reg[2] | sync2_reg[1]) & ~mux_busy;
    assign ref_low    = sync2_reg[0];

    // ------------------------------------------------------------
    // Alarm flags
    // ------------------------------------------------------------
    // A flag may only drop at a conversion start, so software reading between
    // conversions sees a stable value; a new overload sets it at once, except while mux_switching is high.
    afm_status_s status_reg;
    always_ff @(posedge clk) begin
        if (!resetn) begin
            status_reg <= '0;
        end else begin
            if (over_high) begin
                status_reg.amp_high_alarm <= 1'b1;
            end else if (conv_pulse) begin
                status_reg.amp_high_alarm <= 1'b0;
            end
            if (over_low) begin
                status_reg.amp_low_alarm <= 1'b1;
            end else if (conv_pulse) begin
                status_reg.amp_low_alarm <= 1'b0;
            end
            if (ref_low) begin
                status_reg.ref_low_alarm <= 1'b1;
            end else if (conv_pulse) begin
                status_reg.ref_low_alarm <= 1'b0;
            end
        end
    end
    assign status = status_reg;

    // ------------------------------------------------------------
    // Configuration registers and AHB-Lite slave
    // ------------------------------------------------------------
    logic [1:0] ref_pos_select_reg;
    logic [1:0] ref_neg_select_reg;
    logic       ref_on_reg;
    logic       shift_reg;
    logic       bypass_reg;
    logic [2:0] gain_reg;
    logic       pullup_reg;
    logic [2:0] burn_reg;
    afm_exc_s   exc1_reg;
    afm_exc_s   exc2_reg;
    afm_src_e   src_reg;
    logic [7:0] gainf_reg;
    logic [31:0] rdata_reg;
    logic        wr_pend_reg;
    logic [7:0]  wr_addr_reg;

    logic addr_ok;
    assign addr_ok = hsel & hready & htrans[1];

    always_ff @(posedge clk) begin
        if (!resetn) begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 8'h00;
        end else begin
            wr_pend_reg <= addr_ok & hwrite;
            wr_addr_reg <= haddr[7:0];
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            ref_pos_select_reg <= AFM_REF_SUPPLY;
            ref_neg_select_reg <= AFM_REF_SUPPLY;
            ref_on_reg <= 1'b0;
            shift_reg  <= 1'b0;
            bypass_reg <= 1'b0;
            gain_reg   <= 3'h0;
            pullup_reg <= 1'b0;
            burn_reg   <= 3'h0;
            exc1_reg   <= '0;
            exc2_reg   <= '0;
        end else if (wr_pend_reg) begin
            case (wr_addr_reg)
                AFM_ADDR_REF: begin
                    ref_pos_select_reg <= hwdata[1:0];
                    ref_neg_select_reg <= hwdata[3:2];
                    ref_on_reg <= hwdata[4];
                end
                AFM_ADDR_INPUT: begin
                    gain_reg   <= hwdata[2:0];
                    bypass_reg <= hwdata[3];
                    shift_reg  <= hwdata[4];
                end
                AFM_ADDR_BURN: begin
                    // Codes above the top level are clamped to keep five choices.
                    burn_reg   <= (hwdata[2:0] > AFM_BURN_MAX) ? AFM_BURN_MAX : hwdata[2:0];
                    pullup_reg <= hwdata[3];
                end
                AFM_ADDR_EXC: begin
                    exc1_reg <= hwdata[7:0];
                    exc2_reg <= hwdata[15:8];
                end
                default: begin
                end
            endcase
        end
    end

    // Mixed selections (for example internal positive with supply negative) are
    // passed through as a flag; the analog side decides what that means.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            src_reg   <= AFM_SRC_SUPPLY;
            gainf_reg <= 8'h01;
        end else begin
            if (ref_pos_select_reg != ref_neg_select_reg) begin
                src_reg <= AFM_SRC_MIXED;
            end else begin
                case (ref_pos_select_reg)
                    AFM_REF_INTERNAL: src_reg <= AFM_SRC_INTERNAL;
                    AFM_REF_SUPPLY:   src_reg <= AFM_SRC_SUPPLY;
                    AFM_REF_EXT0:     src_reg <= AFM_SRC_EXT01;
                    AFM_REF_EXT1:     src_reg <= AFM_SRC_EXT23;
                    default:          src_reg <= AFM_SRC_SUPPLY;
                endcase
            end
            gainf_reg <= 8'h01 << gain_reg;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            rdata_reg <= 32'h0;
        end else if (addr_ok & ~hwrite) begin
            case (haddr[7:0])
                AFM_ADDR_REF:    rdata_reg <= {27'h0, ref_on_reg, ref_neg_select_reg,
                                               ref_pos_select_reg};
                AFM_ADDR_INPUT:  rdata_reg <= {27'h0, shift_reg, bypass_reg, gain_reg};
                AFM_ADDR_BURN:   rdata_reg <= {28'h0, pullup_reg, burn_reg};
                AFM_ADDR_EXC:    rdata_reg <= {16'h0, exc2_reg, exc1_reg};
                AFM_ADDR_STATUS: rdata_reg <= {29'h0, status_reg};
                AFM_ADDR_ROUTE:  rdata_reg <= {21'h0, src_reg, gainf_reg};
                default:         rdata_reg <= 32'h0;
            endcase
        end
    end

    assign hrdata     = rdata_reg;
    assign hreadyout  = 1'b1;
    assign hresp      = 1'b0;

    assign ref_source          = src_reg;
    assign internal_ref_on     = ref_on_reg;
    assign level_shift_switch  = shift_reg;
    assign amp_bypass          = bypass_reg;
    assign gain_factor         = gainf_reg;
    assign burn_pullup         = pullup_reg;
    assign burn_level          = burn_reg;
    assign excitation_source_1 = exc1_reg;
    assign excitation_source_2 = exc2_reg;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    high_set_a: assert property (over_high |=> status_reg.amp_high_alarm)
        else $error("high alarm not set");
    low_set_a: assert property (over_low |=> status_reg.amp_low_alarm)
        else $error("low alarm not set");
    high_hold_a: assert property ($fell(status_reg.amp_high_alarm) |-> $past(conv_pulse))
        else $error("high alarm cleared outside conversion start");
    mux_mask_a: assert property (mux_busy |=> !$rose(status_reg.amp_low_alarm))
        else $error("alarm raised during mux switching");
    high_mask_a: assert property (mux_busy |=> !$rose(status_reg.amp_high_alarm))
        else $error("high alarm raised during mux switching");
    ref_set_a: assert property (ref_low |=> status_reg.ref_low_alarm)
        else $error("ref low alarm not set");
    ref_clear_a: assert property (conv_pulse && !ref_low |=> !status_reg.ref_low_alarm)
        else $error("ref low alarm not cleared");
    int_ref_a: assert property (ref_pos_select_reg == AFM_REF_INTERNAL &&
        ref_neg_select_reg == AFM_REF_INTERNAL |=> src_reg == AFM_SRC_INTERNAL)
        else $error("internal reference not routed");
    ext_ref_a: assert property (ref_pos_select_reg == AFM_REF_EXT1 &&
        ref_neg_select_reg == AFM_REF_EXT1 |=> src_reg == AFM_SRC_EXT23)
        else $error("external pair 2/3 not routed");
    gain_map_a: assert property (##1 gainf_reg == (8'h01 << $past(gain_reg)))
        else $error("gain factor mismatch");
    burn_max_a: assert property (burn_reg <= AFM_BURN_MAX)
        else $error("burn level out of range");

    high_cov_c: cover property (status_reg.amp_high_alarm ##1 conv_pulse);
    ref_cov_c: cover property ($fell(status_reg.ref_low_alarm));
    wr_cov_c: cover property (wr_pend_reg && wr_addr_reg == AFM_ADDR_REF);

endmodule
`default_nettype wire

// *** tb/afm_sensor_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module afm_sensor_model (
    input  wire logic       clk,
    input  wire logic [1:0] over_hi,
    input  wire logic [1:0] over_lo,
    input  wire logic       ref_missing,
    input  wire logic       switching,
    input  wire logic       convert,
    output logic            cmp_outp_high,
    output logic            cmp_outn_high,
    output logic            cmp_outp_low,
    output logic            cmp_outn_low,
    output logic            cmp_ref_low,
    output logic            mux_switching,
    output logic            conv_start
);
    // Analog levels move one edge after the request, as slow comparators would.
    // Bit 0 of each overload pair is the positive output, bit 1 the negative.
    always_ff @(posedge clk) begin
        {cmp_outn_high, cmp_outp_high} <= over_hi;
        {cmp_outn_low, cmp_outp_low}   <= over_lo;
        cmp_ref_low                    <= ref_missing;
        mux_switching                  <= switching;
        conv_start                     <= convert;
    end
endmodule
`default_nettype wire

// *** tb/afe_config_fault_monitor_bench.sv ***
`timescale 1ns/100ps
`default_nettype none
module afe_config_fault_monitor_bench;
    import afm_pkg::*;
    typedef struct {
        logic [7:0]  wa;
        logic [31:0] wd;
        logic [7:0]  ra;
        logic [31:0] m;
        logic [31:0] e;
    } afm_row_s;
    logic clk = 0, resetn = 0, hsel = 0, hwrite = 0, convert = 0, sw = 0, rm = 0;
    logic [31:0] haddr = '0, hwdata = '0, hrdata, r;
    logic [1:0]  htrans = '0, ovh = '0, ovl = '0;
    logic [2:0]  hsize = '0, burn_level;
    logic hready, hreadyout, hresp, conv_start, mux_switching, c_ph, c_nh, c_pl, c_nl, c_rl;
    logic internal_ref_on, level_shift_switch, amp_bypass, burn_pullup;
    logic [7:0]  gain_factor;
    afm_status_s status;
    afm_src_e    ref_source;
    afm_exc_s    exc1, exc2;
    int failures = 0, n_compared = 0;
    localparam int REF_SETTLE = 100;
    afm_row_s rows [14] = '{
        '{AFM_ADDR_REF, 32'h00, AFM_ADDR_ROUTE, 32'h700, 32'h000},
        '{AFM_ADDR_REF, 32'h0a, AFM_ADDR_ROUTE, 32'h700, 32'h200},
        '{AFM_ADDR_REF, 32'h0f, AFM_ADDR_ROUTE, 32'h700, 32'h300},
        '{AFM_ADDR_REF, 32'h05, AFM_ADDR_ROUTE, 32'h700, 32'h100},
        '{AFM_ADDR_REF, 32'h09, AFM_ADDR_ROUTE, 32'h700, 32'h400},
        '{AFM_ADDR_REF, 32'h15, AFM_ADDR_REF, 32'h1f, 32'h15},
        '{AFM_ADDR_INPUT, 32'h00, AFM_ADDR_ROUTE, 32'hff, 32'h01},
        '{AFM_ADDR_INPUT, 32'h07, AFM_ADDR_ROUTE, 32'hff, 32'h80},
        '{AFM_ADDR_INPUT, 32'h03, AFM_ADDR_ROUTE, 32'hff, 32'h08},
        '{AFM_ADDR_BURN, 32'h0f, AFM_ADDR_BURN, 32'h0f, 32'h0c},
        '{AFM_ADDR_BURN, 32'h04, AFM_ADDR_BURN, 32'h0f, 32'h04},
        '{AFM_ADDR_EXC, 32'h5a3c, AFM_ADDR_EXC, 32'hffff, 32'h5a3c},
        '{AFM_ADDR_STATUS, 32'h07, AFM_ADDR_STATUS, 32'h07, 32'h00},
        '{8'h40, 32'hffff, 8'h40, 32'hffffffff, 32'h0}
    };
    assign hready = hreadyout;
    always #50 clk = ~clk;
    afm_sensor_model partner (.clk(clk), .over_hi(ovh), .over_lo(ovl), .ref_missing(rm),
        .switching(sw), .convert(convert), .cmp_outp_high(c_ph), .cmp_outn_high(c_nh),
        .cmp_outp_low(c_pl), .cmp_outn_low(c_nl), .cmp_ref_low(c_rl),
        .mux_switching(mux_switching), .conv_start(conv_start));
    afm_afe_monitor dut (.clk(clk), .resetn(resetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .conv_start(conv_start),
        .mux_switching(mux_switching), .cmp_outp_high(c_ph), .cmp_outn_high(c_nh),
        .cmp_outp_low(c_pl), .cmp_outn_low(c_nl), .cmp_ref_low(c_rl), .status(status),
        .ref_source(ref_source), .internal_ref_on(internal_ref_on),
        .level_shift_switch(level_shift_switch), .amp_bypass(amp_bypass),
        .gain_factor(gain_factor), .burn_pullup(burn_pullup), .burn_level(burn_level),
        .excitation_source_1(exc1), .excitation_source_2(exc2));
    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic finish_test;
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input string name, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            $display("BAD %s expected %h seen %h", name, e, g);
            failures++;
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    // The slave may stretch either phase, so both waits are bounded loops.
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] rd);
        int n;
        @(posedge clk);
        hsel <= 1;
        haddr <= {24'h0, a};
        hwrite <= w;
        htrans <= 2'h2;
        hsize <= 3'h2;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (hreadyout !== 1'b1 && n < 50);
        if (hreadyout !== 1'b1) begin
            failures++;
            finish_test();
        end
        htrans <= 2'h0;
        hsel <= 0;
        hwdata <= d;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (hreadyout !== 1'b1 && n < 50);
        rd = hrdata;
        if (hreadyout !== 1'b1) begin
            failures++;
            finish_test();
        end
    endtask
    task automatic conv_pulse;
        convert <= 1;
        cyc(3);
        convert <= 0;
        cyc(6);
    endtask
    // ------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------
    initial begin
        cyc(4);
        resetn <= 1;
        bus(0, AFM_ADDR_REF, 0, r);
        chk("ref_reset", 32'h05, r & 32'h1f);
        chk("src_reset", AFM_SRC_SUPPLY, ref_source);
        chk("hresp", 0, hresp);
        foreach (rows[i]) begin
            bus(1, rows[i].wa, rows[i].wd, r);
            bus(0, rows[i].ra, 0, r);
            chk($sformatf("row%0d", i), rows[i].e, r & rows[i].m);
        end
        cyc(REF_SETTLE);
        chk("ref_on", 1, internal_ref_on);
        chk("gain", 8'h08, gain_factor);
        chk("exc", 16'h5a3c, {exc2, exc1});
        bus(1, AFM_ADDR_INPUT, 32'h1b, r);
        bus(1, AFM_ADDR_BURN, 32'h0b, r);
        cyc(2200);
        chk("shift_bypass", 2'b11, {level_shift_switch, amp_bypass});
        chk("burn", 4'hb, {burn_pullup, burn_level});
        ovh <= 2'b10;
        cyc(6);
        chk("high", 1, status.amp_high_alarm);
        bus(0, AFM_ADDR_STATUS, 0, r);
        chk("status_rd", 32'h4, r);
        ovh <= 0;
        cyc(6);
        chk("high_hold", 1, status.amp_high_alarm);
        conv_pulse();
        chk("high_clr", 0, status.amp_high_alarm);
        sw <= 1;
        ovl <= 2'b01;
        cyc(6);
        chk("low_mask", 0, status.amp_low_alarm);
        sw <= 0;
        cyc(6);
        chk("low", 1, status.amp_low_alarm);
        ovl <= 0;
        conv_pulse();
        chk("low_clr", 0, status.amp_low_alarm);
        sw <= 1;
        ovh <= 2'b01;
        cyc(6);
        chk("high_mask", 0, status.amp_high_alarm);
        sw <= 0;
        cyc(6);
        chk("high_p", 1, status.amp_high_alarm);
        ovh <= 0;
        conv_pulse();
        chk("high_p_clr", 0, status.amp_high_alarm);
        rm <= 1;
        cyc(6);
        conv_pulse();
        chk("ref_hold", 1, status.ref_low_alarm);
        rm <= 0;
        cyc(6);
        conv_pulse();
        chk("ref_clr", 0, status.ref_low_alarm);
        // A mid-run reset must restore the defaults even while faults are present.
        bus(1, AFM_ADDR_REF, 32'h1a, r);
        ovl <= 2'b10;
        rm <= 1;
        cyc(6);
        chk("pre_rst", 3'b011, status);
        resetn <= 0;
        cyc(2);
        chk("rst_status", 0, status);
        chk("rst_ref_on", 0, internal_ref_on);
        chk("rst_rdata", 0, hrdata);
        resetn <= 1;
        cyc(2);
        chk("rst_src", AFM_SRC_SUPPLY, ref_source);
        chk("rst_flags", 0, status);
        cyc(2);
        chk("post_rst", 3'b011, status);
        bus(0, AFM_ADDR_REF, 0, r);
        chk("ref_rst_rd", 32'h05, r & 32'h1f);
        ovl <= 0;
        rm <= 0;
        conv_pulse();
        chk("all_clr", 0, status);
        finish_test();
    end
endmodule
`default_nettype wire
